//--- inc/epd_cmd_pkg.sv
// shared constants for the e-paper sense and update command decoder
package epd_cmd_pkg;
    // ==========================================================
    // command bytes
    localparam logic [7:0] CMD_SUPPLY_DETECT = 8'h15;
    localparam logic [7:0] CMD_TEMP_SELECT = 8'h18;
    localparam logic [7:0] CMD_TEMP_WRITE = 8'h1A;
    localparam logic [7:0] CMD_TEMP_READ = 8'h1B;
    localparam logic [7:0] CMD_MASTER_ACT = 8'h20;
    localparam logic [7:0] CMD_RAM_OPTION = 8'h21;
    localparam logic [7:0] CMD_SEQ_OPTION = 8'h22;
    localparam logic [7:0] CMD_STATUS_READ = 8'h2F;
    // ==========================================================
    // power-on values and codes
    localparam logic [2:0] THRESH_DEFAULT = 3'h4;
    localparam logic [2:0] THRESH_LOWEST = 3'h3;
    localparam logic [7:0] TEMP_SEL_EXTERNAL = 8'h48;
    localparam logic [7:0] TEMP_SEL_INTERNAL = 8'h80;
    localparam logic [11:0] TEMP_DEFAULT = 12'h7FF;
    localparam logic [7:0] RAM_OPT_DEFAULT = 8'h00;
    localparam logic [7:0] SEQ_OPT_DEFAULT = 8'hFF;
    localparam logic [3:0] PLANE_NORMAL = 4'h0;
    localparam logic [3:0] PLANE_ZERO = 4'h4;
    localparam logic [3:0] PLANE_INVERT = 4'h8;
    localparam int SEQ_CLOCK_BIT = 7;
    localparam int SEQ_ANALOG_BIT = 6;
    localparam int STATUS_DETECT_BIT = 5;
    localparam int TEMP_NIBBLE = 4;
    // ==========================================================
    // register map, byte addresses
    localparam logic [4:0] REG_IRQ_STATUS = 5'h00;
    localparam logic [4:0] REG_IRQ_MASK = 5'h04;
    localparam logic [4:0] REG_SETTINGS = 5'h08;
    localparam logic [4:0] REG_TEMP = 5'h0C;
    localparam int IRQ_DETECT_DONE = 0;
    localparam int IRQ_UPDATE_DONE = 1;
    localparam int IRQ_TEMP_WRITTEN = 2;
    localparam int IRQ_WIDTH = 3;
    localparam int SET_THRESH_LSB = 0;
    localparam int SET_RAM_LSB = 8;
    localparam int SET_TSEL_LSB = 16;
    localparam int SET_SEQ_LSB = 24;
    localparam int TEMP_BUSY_BIT = 16;
    localparam int TEMP_LOW_BIT = 17;
    // ==========================================================
    // timing
    localparam int CLK_FREQ_MHZ = 50;
    localparam int DETECT_TIME_US = 100;
    localparam int UPDATE_TIME_US = 1000;
    localparam int DETECT_CYCLES = DETECT_TIME_US * CLK_FREQ_MHZ;
    localparam int UPDATE_CYCLES = UPDATE_TIME_US * CLK_FREQ_MHZ;
    // ==========================================================
    // sequencer states
    typedef enum logic [2:0] {
        SEQ_IDLE = 3'b001,
        SEQ_DETECT = 3'b010,
        SEQ_UPDATE = 3'b100
    } seq_state_type;
endpackage : epd_cmd_pkg

//--- src/epd_sense_update.sv
// command decoder: supply detect, temperature, master activation, ram option
// Operation
// [RULE_01] 0x15 sets 3-bit threshold, default 100
// [RULE_02] threshold codes 011 to 111 only
// [RULE_03] host enables clock and analog stages first
// [RULE_04] detect parameter starts supply detection
// [RULE_05] busy high throughout supply detection
// [RULE_06] detect outcome readable by 0x2F
// [RULE_07] 0x18 selects sensor: 48h external, 80h internal
// [RULE_08] 0x1A writes 12-bit temperature, default 7FF
// [RULE_09] 0x1B reads temperature as two bytes
// [RULE_10] 0x20 launches selected update stages
// [RULE_11] busy high while update sequence runs
// [RULE_12] host waits out update sequence
// [RULE_13] 0x21 sets ram option, default 00h
// [RULE_14] upper nibble: red plane normal/zero/invert
// [RULE_15] lower nibble: black-white plane same codes
// [RULE_16] sequence option selects stages, default FFh
// [RULE_17] command dc low, parameters dc high
// [RULE_18] host sends nothing while busy
//
// The address map and register access over Avalon-MM were decided locally.
`timescale 1ns/1ps
module epd_sense_update #(
    parameter int DETECT_CYCLES = epd_cmd_pkg::DETECT_CYCLES,
    parameter int UPDATE_CYCLES = epd_cmd_pkg::UPDATE_CYCLES
) (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic spi_cs_n_in,
    input wire logic spi_sclk_in,
    input wire logic spi_sdio_in,
    input wire logic spi_dc_in,
    input wire logic supply_ok_in,
    output logic spi_sdio_out,
    output logic spi_sdio_oe_out,
    output logic busy_out,
    output logic [2:0] supply_threshold_out,
    output logic detect_active_out,
    output logic update_active_out,
    output logic [7:0] update_stages_out,
    output logic temp_internal_out,
    output logic [11:0] temperature_out,
    output logic red_zero_out,
    output logic red_invert_out,
    output logic bw_zero_out,
    output logic bw_invert_out,
    input wire logic [4:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    output logic irq_out
);
    generate
        if (DETECT_CYCLES < 1 || UPDATE_CYCLES < 1) begin : g_bad_param
            $error("sequence lengths must be at least one cycle");
        end
    endgenerate

    // ==========================================================
    // serial link
    logic [7:0] rx_byte;
    logic rx_dc;
    logic rx_valid;
    logic [7:0] tx_byte_reg;
    logic read_mode_reg;

    spi3_link u_link (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .spi_cs_n_in(spi_cs_n_in),
        .spi_sclk_in(spi_sclk_in),
        .spi_sdio_in(spi_sdio_in),
        .spi_dc_in(spi_dc_in),
        .tx_byte_in(tx_byte_reg),
        .tx_en_in(read_mode_reg),
        .spi_sdio_out(spi_sdio_out),
        .spi_sdio_oe_out(spi_sdio_oe_out),
        .rx_byte_out(rx_byte),
        .rx_dc_out(rx_dc),
        .rx_valid_out(rx_valid)
    );

    // ==========================================================
    // decode
    logic [7:0] cmd_reg;
    logic [1:0] param_idx_reg;
    logic [7:0] temp_hi_reg;
    logic [2:0] thresh_reg;
    logic [7:0] temp_sel_reg;
    logic [11:0] temp_reg;
    logic [7:0] ram_opt_reg;
    logic [7:0] seq_opt_reg;
    logic detect_low_reg;
    logic cmd_byte;
    logic param_byte;
    logic detect_go;
    logic update_go;
    logic temp_written;
    epd_cmd_pkg::seq_state_type seq_state_reg;

    assign cmd_byte = rx_valid & ~rx_dc; // see [RULE_17]
    assign param_byte = rx_valid & rx_dc & ~read_mode_reg; // see [RULE_17]
    assign detect_go = param_byte && cmd_reg == epd_cmd_pkg::CMD_SUPPLY_DETECT
        && param_idx_reg == 2'h0 && rx_byte[2:0] >= epd_cmd_pkg::THRESH_LOWEST
        && seq_state_reg == epd_cmd_pkg::SEQ_IDLE; // see [RULE_04]
    assign update_go = cmd_byte && rx_byte == epd_cmd_pkg::CMD_MASTER_ACT
        && seq_state_reg == epd_cmd_pkg::SEQ_IDLE; // see [RULE_10]
    assign temp_written = param_byte && cmd_reg == epd_cmd_pkg::CMD_TEMP_WRITE
        && param_idx_reg == 2'h1;

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            cmd_reg <= 8'h00;
            param_idx_reg <= 2'h0;
        end else if (cmd_byte) begin
            cmd_reg <= rx_byte;
            param_idx_reg <= 2'h0;
        end else if (rx_valid && param_idx_reg != 2'h3) begin
            param_idx_reg <= param_idx_reg + 2'h1;
        end
    end

    // parameter stores; an unavailable threshold code is dropped
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            thresh_reg <= epd_cmd_pkg::THRESH_DEFAULT; // see [RULE_01]
            temp_sel_reg <= epd_cmd_pkg::TEMP_SEL_EXTERNAL; // see [RULE_07]
            temp_reg <= epd_cmd_pkg::TEMP_DEFAULT; // see [RULE_08]
            temp_hi_reg <= 8'h00;
            ram_opt_reg <= epd_cmd_pkg::RAM_OPT_DEFAULT; // see [RULE_13]
            seq_opt_reg <= epd_cmd_pkg::SEQ_OPT_DEFAULT; // see [RULE_16]
        end else if (param_byte && param_idx_reg == 2'h0) begin
            case (cmd_reg)
                epd_cmd_pkg::CMD_SUPPLY_DETECT: begin
                    if (rx_byte[2:0] >= epd_cmd_pkg::THRESH_LOWEST) begin
                        thresh_reg <= rx_byte[2:0]; // see [RULE_02]
                    end
                end
                epd_cmd_pkg::CMD_TEMP_SELECT: temp_sel_reg <= rx_byte; // see [RULE_07]
                epd_cmd_pkg::CMD_TEMP_WRITE: temp_hi_reg <= rx_byte; // see [RULE_08]
                epd_cmd_pkg::CMD_RAM_OPTION: ram_opt_reg <= rx_byte; // see [RULE_13]
                epd_cmd_pkg::CMD_SEQ_OPTION: seq_opt_reg <= rx_byte; // see [RULE_16]
                default: begin
                end
            endcase
        end else if (temp_written) begin
            temp_reg <= {temp_hi_reg, rx_byte[7:4]}; // see [RULE_08]
        end
    end

    // ==========================================================
    // read-back bytes; the next byte is ready well before its first bit
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            read_mode_reg <= 1'b0;
            tx_byte_reg <= 8'h00;
        end else if (cmd_byte && rx_byte == epd_cmd_pkg::CMD_TEMP_READ) begin
            read_mode_reg <= 1'b1;
            tx_byte_reg <= temp_reg[11:4]; // see [RULE_09]
        end else if (cmd_byte && rx_byte == epd_cmd_pkg::CMD_STATUS_READ) begin
            read_mode_reg <= 1'b1;
            tx_byte_reg <= 8'h00;
            tx_byte_reg[epd_cmd_pkg::STATUS_DETECT_BIT] <= detect_low_reg; // see [RULE_06]
        end else if (cmd_byte) begin
            read_mode_reg <= 1'b0;
        end else if (rx_valid && read_mode_reg) begin
            if (cmd_reg == epd_cmd_pkg::CMD_TEMP_READ && param_idx_reg == 2'h0) begin
                tx_byte_reg <= {temp_reg[3:0], 4'h0}; // see [RULE_09]
            end else begin
                read_mode_reg <= 1'b0;
            end
        end
    end

    // ==========================================================
    // busy sequencer
    logic supply_s1_reg;
    logic supply_s2_reg;
    logic [31:0] seq_cnt_reg;
    logic seq_last;

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            supply_s1_reg <= 1'b1;
            supply_s2_reg <= 1'b1;
        end else begin
            supply_s1_reg <= supply_ok_in;
            supply_s2_reg <= supply_s1_reg;
        end
    end

    assign seq_last = seq_cnt_reg == 32'h0000_0001;

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            seq_state_reg <= epd_cmd_pkg::SEQ_IDLE;
            seq_cnt_reg <= 32'h0000_0000;
            update_stages_out <= 8'h00;
            detect_low_reg <= 1'b0;
        end else begin
            case (seq_state_reg)
                epd_cmd_pkg::SEQ_IDLE: begin
                    if (detect_go) begin
                        seq_state_reg <= epd_cmd_pkg::SEQ_DETECT; // see [RULE_04]
                        seq_cnt_reg <= 32'(DETECT_CYCLES);
                    end else if (update_go) begin
                        seq_state_reg <= epd_cmd_pkg::SEQ_UPDATE; // see [RULE_10]
                        seq_cnt_reg <= 32'(UPDATE_CYCLES);
                        update_stages_out <= seq_opt_reg; // see [RULE_16]
                    end
                end
                epd_cmd_pkg::SEQ_DETECT: begin
                    seq_cnt_reg <= seq_cnt_reg - 32'h0000_0001;
                    if (seq_last) begin
                        seq_state_reg <= epd_cmd_pkg::SEQ_IDLE; // see [RULE_05]
                        detect_low_reg <= ~supply_s2_reg; // see [RULE_06]
                    end
                end
                epd_cmd_pkg::SEQ_UPDATE: begin
                    seq_cnt_reg <= seq_cnt_reg - 32'h0000_0001;
                    if (seq_last) begin
                        seq_state_reg <= epd_cmd_pkg::SEQ_IDLE; // see [RULE_11]
                        update_stages_out <= 8'h00;
                    end
                end
                default: seq_state_reg <= epd_cmd_pkg::SEQ_IDLE;
            endcase
        end
    end

    assign busy_out = seq_state_reg != epd_cmd_pkg::SEQ_IDLE; // see [RULE_05] see [RULE_11]
    assign detect_active_out = seq_state_reg == epd_cmd_pkg::SEQ_DETECT;
    assign update_active_out = seq_state_reg == epd_cmd_pkg::SEQ_UPDATE;
    assign supply_threshold_out = thresh_reg;
    assign temp_internal_out = temp_sel_reg == epd_cmd_pkg::TEMP_SEL_INTERNAL;
    assign temperature_out = temp_reg;
    // unlisted nibble codes fall back to normal use of the plane
    assign red_zero_out = ram_opt_reg[7:4] == epd_cmd_pkg::PLANE_ZERO; // see [RULE_14]
    assign red_invert_out = ram_opt_reg[7:4] == epd_cmd_pkg::PLANE_INVERT; // see [RULE_14]
    assign bw_zero_out = ram_opt_reg[3:0] == epd_cmd_pkg::PLANE_ZERO; // see [RULE_15]
    assign bw_invert_out = ram_opt_reg[3:0] == epd_cmd_pkg::PLANE_INVERT; // see [RULE_15]

    // ==========================================================
    // register slave and interrupts
    localparam int IRQ_W = epd_cmd_pkg::IRQ_WIDTH;
    logic ack_reg;
    logic bus_take;
    logic [IRQ_W-1:0] irq_status_reg;
    logic [IRQ_W-1:0] irq_mask_reg;
    logic [IRQ_W-1:0] irq_events;
    logic [31:0] rd_word;

    assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_reg;
    assign bus_take = (avs_read_in | avs_write_in) & ack_reg;
    assign irq_events[epd_cmd_pkg::IRQ_DETECT_DONE] = detect_active_out & seq_last;
    assign irq_events[epd_cmd_pkg::IRQ_UPDATE_DONE] = update_active_out & seq_last;
    assign irq_events[epd_cmd_pkg::IRQ_TEMP_WRITTEN] = temp_written;
    assign irq_out = |(irq_status_reg & irq_mask_reg);

    always_comb begin
        rd_word = 32'h0000_0000;
        case (avs_address_in)
            epd_cmd_pkg::REG_IRQ_STATUS: rd_word[IRQ_W-1:0] = irq_status_reg;
            epd_cmd_pkg::REG_IRQ_MASK: rd_word[IRQ_W-1:0] = irq_mask_reg;
            epd_cmd_pkg::REG_SETTINGS: begin
                rd_word[epd_cmd_pkg::SET_THRESH_LSB +: 3] = thresh_reg;
                rd_word[epd_cmd_pkg::SET_RAM_LSB +: 8] = ram_opt_reg;
                rd_word[epd_cmd_pkg::SET_TSEL_LSB +: 8] = temp_sel_reg;
                rd_word[epd_cmd_pkg::SET_SEQ_LSB +: 8] = seq_opt_reg;
            end
            epd_cmd_pkg::REG_TEMP: begin
                rd_word[11:0] = temp_reg;
                rd_word[epd_cmd_pkg::TEMP_BUSY_BIT] = busy_out;
                rd_word[epd_cmd_pkg::TEMP_LOW_BIT] = detect_low_reg;
            end
            default: rd_word = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ack_reg <= 1'b0;
            avs_readdata_out <= 32'h0000_0000;
        end else begin
            ack_reg <= (avs_read_in | avs_write_in) & ~ack_reg;
            if (avs_read_in && !ack_reg) begin
                avs_readdata_out <= rd_word;
            end
        end
    end

    // a read clears only the bits it reported, so a late event is not lost
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            irq_status_reg <= '0;
        end else if (bus_take && avs_read_in && avs_address_in == epd_cmd_pkg::REG_IRQ_STATUS) begin
            irq_status_reg <= (irq_status_reg & ~avs_readdata_out[IRQ_W-1:0]) | irq_events;
        end else begin
            irq_status_reg <= irq_status_reg | irq_events;
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            irq_mask_reg <= '0;
        end else if (bus_take && avs_write_in && avs_byteenable_in[0]
                     && avs_address_in == epd_cmd_pkg::REG_IRQ_MASK) begin
            irq_mask_reg <= avs_writedata_in[IRQ_W-1:0];
        end
    end

    // ==========================================================
    // assertions
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (rst_in);

    a_detect_start: assert property (detect_go |=> busy_out && detect_active_out) // see [RULE_04]
        else $error("detection did not start");
    a_detect_busy: assert property ($rose(detect_active_out) |-> busy_out [*8]) // see [RULE_05]
        else $error("busy dropped during detection");
    a_detect_result: assert property ($fell(detect_active_out)
        |-> !busy_out && detect_low_reg == !$past(supply_s2_reg)) // see [RULE_06]
        else $error("detection result not captured");
    a_thresh_guard: assert property (param_byte && cmd_reg == epd_cmd_pkg::CMD_SUPPLY_DETECT
        && rx_byte[2:0] < epd_cmd_pkg::THRESH_LOWEST |=> $stable(thresh_reg)) // see [RULE_02]
        else $error("unavailable threshold code stored");
    a_update_start: assert property (update_go |=> update_active_out
        && update_stages_out == $past(seq_opt_reg)) // see [RULE_10]
        else $error("update sequence did not launch");
    a_update_busy: assert property ($fell(update_active_out) |-> $past(seq_last) && !busy_out) // see [RULE_11]
        else $error("update ended early or busy stuck");
    a_temp_write: assert property (temp_written
        |=> temp_reg == {$past(temp_hi_reg), $past(rx_byte[7:4])}) // see [RULE_08]
        else $error("temperature write mismatch");
    a_temp_read: assert property (cmd_byte && rx_byte == epd_cmd_pkg::CMD_TEMP_READ
        |=> read_mode_reg && tx_byte_reg == temp_reg[11:4]) // see [RULE_09]
        else $error("temperature read byte wrong");
    a_ram_option: assert property (param_byte && param_idx_reg == 2'h0
        && cmd_reg == epd_cmd_pkg::CMD_RAM_OPTION |=> ram_opt_reg == $past(rx_byte)) // see [RULE_13]
        else $error("ram option not stored");
    a_bus_answer: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
        |=> !avs_waitrequest_out) // bus access timing is a local choice, not one of the listed rules
        else $error("bus answer late");

    c_detect_done: cover property ($fell(detect_active_out));
    c_update_done: cover property ($fell(update_active_out));
    c_temp_read: cover property (read_mode_reg && rx_valid ##[1:1000] !read_mode_reg);
    c_irq: cover property ($rose(irq_out));
endmodule : epd_sense_update

//--- src/spi3_link.sv
// serial link byte engine: pin synchronisers, bit shifting, read drive
`timescale 1ns/1ps
module spi3_link (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic spi_cs_n_in,
    input wire logic spi_sclk_in,
    input wire logic spi_sdio_in,
    input wire logic spi_dc_in,
    input wire logic [7:0] tx_byte_in,
    input wire logic tx_en_in,
    output logic spi_sdio_out,
    output logic spi_sdio_oe_out,
    output logic [7:0] rx_byte_out,
    output logic rx_dc_out,
    output logic rx_valid_out
);
    // ==========================================================
    // synchronisers
    logic [3:0] sync1_reg;
    logic [3:0] sync2_reg;
    logic sclk_prev_reg;
    logic [2:0] bit_cnt_reg;
    logic [7:0] rx_sh_reg;
    logic [7:0] tx_sh_reg;
    logic sclk_rise;
    logic sclk_fall;
    logic cs_active;

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            sync1_reg <= 4'h1;
            sync2_reg <= 4'h1;
            sclk_prev_reg <= 1'b0;
        end else begin
            sync1_reg <= {spi_dc_in, spi_sdio_in, spi_sclk_in, spi_cs_n_in};
            sync2_reg <= sync1_reg;
            sclk_prev_reg <= sync2_reg[1];
        end
    end

    assign cs_active = ~sync2_reg[0];
    assign sclk_rise = cs_active & sync2_reg[1] & ~sclk_prev_reg;
    assign sclk_fall = cs_active & ~sync2_reg[1] & sclk_prev_reg;

    // ==========================================================
    // shifting, msb first, sampled on the rising clock edge
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            bit_cnt_reg <= 3'h0;
            rx_sh_reg <= 8'h00;
            tx_sh_reg <= 8'h00;
            rx_byte_out <= 8'h00;
            rx_dc_out <= 1'b0;
            rx_valid_out <= 1'b0;
        end else begin
            rx_valid_out <= 1'b0;
            if (!cs_active) begin
                bit_cnt_reg <= 3'h0;
            end else if (sclk_rise) begin
                rx_sh_reg <= {rx_sh_reg[6:0], sync2_reg[2]};
                bit_cnt_reg <= bit_cnt_reg + 3'h1;
                if (bit_cnt_reg == 3'h0) begin
                    tx_sh_reg <= {tx_byte_in[6:0], 1'b0};
                end else begin
                    tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
                end
                if (bit_cnt_reg == 3'h7) begin
                    rx_byte_out <= {rx_sh_reg[6:0], sync2_reg[2]};
                    rx_dc_out <= sync2_reg[3];
                    rx_valid_out <= 1'b1;
                end
            end
        end
    end

    // ==========================================================
    // read drive: first bit set up before the first rising edge
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            spi_sdio_out <= 1'b0;
            spi_sdio_oe_out <= 1'b0;
        end else begin
            spi_sdio_oe_out <= cs_active & tx_en_in;
            if (bit_cnt_reg == 3'h0 && !sync2_reg[1]) begin
                spi_sdio_out <= tx_byte_in[7];
            end else if (sclk_fall) begin
                spi_sdio_out <= tx_sh_reg[7];
            end
        end
    end
endmodule : spi3_link

//--- tb/spi_host_model.sv
// host-side model of the three-wire serial link
`timescale 1ns/1ps
module spi_host_model (
    input wire logic core_clk_in,
    input wire logic sdio_in,
    output logic cs_n_out,
    output logic sclk_out,
    output logic sdio_out,
    output logic dc_out
);
    // ==========================================================
    // byte and frame tasks
    initial begin
        cs_n_out = 1'b1;
        sclk_out = 1'b0;
        sdio_out = 1'b0;
        dc_out = 1'b0;
    end
    // four core cycles a half period gives the 160 ns link clock
    task xfer(input logic [7:0] tx, input logic dc, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            sdio_out <= tx[i];
            dc_out <= dc;
            repeat (4) @(posedge core_clk_in);
            sclk_out <= 1'b1;
            rx[i] = sdio_in;
            repeat (4) @(posedge core_clk_in);
            sclk_out <= 1'b0;
        end
    endtask : xfer
    task frame(input logic [7:0] cmd, input int n, input logic [15:0] par,
               output logic [15:0] rd);
        logic [7:0] b;
        cs_n_out <= 1'b0;
        repeat (4) @(posedge core_clk_in);
        xfer(cmd, 1'b0, b);
        for (int k = 0; k < n; k++) begin
            xfer(par[15 - 8 * k -: 8], 1'b1, b);
            rd = {rd[7:0], b};
        end
        // released line shows the inverse so a stale value cannot pass
        sdio_out <= ~sdio_out;
        repeat (4) @(posedge core_clk_in);
        cs_n_out <= 1'b1;
        repeat (8) @(posedge core_clk_in);
    endtask : frame
endmodule : spi_host_model

//--- tb/tb_epaper_sense_update_commands.sv
// self-checking bench for the sense and update command decoder
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin bad_count++; \
    $display("ERROR %0t: value mismatch", $time); end end
module tb_epaper_sense_update_commands;
    logic core_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic spi_cs_n_in, spi_sclk_in, host_sdio, spi_dc_in, supply_ok_in, avs_read_in;
    logic avs_write_in, spi_sdio_out, spi_sdio_oe_out, busy_out, detect_active_out;
    logic update_active_out, temp_internal_out, red_zero_out, red_invert_out;
    logic bw_zero_out, bw_invert_out, avs_waitrequest_out, irq_out;
    logic [2:0] supply_threshold_out;
    logic [3:0] avs_byteenable_in;
    logic [4:0] avs_address_in;
    logic [7:0] update_stages_out, c;
    logic [11:0] temperature_out;
    logic [15:0] rd;
    logic [31:0] avs_writedata_in, avs_readdata_out, q;
    int bad_count = 0;
    int total_checks = 0;
    int cycles = 0;
    wire spi_sdio_in = spi_sdio_oe_out ? spi_sdio_out : host_sdio;
    always #10 core_clk_in = ~core_clk_in;
    spi_host_model i_host (.core_clk_in, .sdio_in(spi_sdio_in), .cs_n_out(spi_cs_n_in),
        .sclk_out(spi_sclk_in), .sdio_out(host_sdio), .dc_out(spi_dc_in));
    epd_sense_update #(.DETECT_CYCLES(20), .UPDATE_CYCLES(40)) i_dut (.core_clk_in,
        .rst_in, .spi_cs_n_in, .spi_sclk_in, .spi_sdio_in, .spi_dc_in, .supply_ok_in,
        .spi_sdio_out, .spi_sdio_oe_out, .busy_out, .supply_threshold_out,
        .detect_active_out, .update_active_out, .update_stages_out, .temp_internal_out,
        .temperature_out, .red_zero_out, .red_invert_out, .bw_zero_out, .bw_invert_out,
        .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in,
        .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out, .irq_out);
    // ==========================================================
    // tasks
    task av(input logic w, input logic [4:0] a, input logic [31:0] d);
        avs_address_in <= a;
        avs_write_in <= w;
        avs_read_in <= !w;
        avs_writedata_in <= d;
        do @(posedge core_clk_in); while (avs_waitrequest_out !== 1'b0);
        q = avs_readdata_out;
        avs_read_in <= 1'b0;
        avs_write_in <= 1'b0;
        @(posedge core_clk_in);
    endtask : av
    // host holds off while busy, so sequences are never interrupted
    task wait_idle;
        int n;
        n = 0;
        while (busy_out !== 1'b0 && n < 200) begin
            @(negedge core_clk_in);
            n++;
        end
        @(posedge core_clk_in);
        `CHK(n < 200, 1'b1)
    endtask : wait_idle
    task finish_test;
        $display("checks %0d errors %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : finish_test
    always @(posedge core_clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            finish_test();
        end
    end
    // ==========================================================
    // tests
    initial begin
        supply_ok_in = 1'b0;
        avs_address_in = 5'h00;
        avs_read_in = 1'b0;
        avs_write_in = 1'b0;
        avs_writedata_in = 32'h0;
        avs_byteenable_in = 4'hF;
        repeat (4) @(posedge core_clk_in);
        rst_in <= 1'b0;
        @(posedge core_clk_in);
        av(0, epd_cmd_pkg::REG_SETTINGS, 0);
        `CHK(q, 32'hFF480004)
        `CHK(temperature_out, 12'h7FF)
        av(1, epd_cmd_pkg::REG_IRQ_MASK, 32'h7);
        av(1, 5'h1C, 32'hFFFFFFFF);
        av(0, 5'h1C, 0);
        `CHK(q, 32'h0)
        i_host.frame(epd_cmd_pkg::CMD_TEMP_WRITE, 2, 16'hA5C0, rd);
        `CHK(temperature_out, 12'hA5C)
        `CHK(irq_out, 1'b1)
        i_host.frame(epd_cmd_pkg::CMD_TEMP_READ, 2, 16'h0, rd);
        `CHK(rd, 16'hA5C0)
        av(0, epd_cmd_pkg::REG_IRQ_STATUS, 0);
        `CHK(q[2:0], 3'h4)
        i_host.frame(epd_cmd_pkg::CMD_TEMP_SELECT, 1, 16'h8000, rd);
        `CHK(temp_internal_out, 1'b1)
        `CHK(irq_out, 1'b0)
        for (int j = 0; j < 3; j++) begin
            c = (j == 0) ? 8'h48 : (j == 1) ? 8'h84 : 8'h00;
            i_host.frame(epd_cmd_pkg::CMD_RAM_OPTION, 1, {c, 8'h00}, rd);
            `CHK({red_zero_out, red_invert_out}, {c[7:4] == 4'h4, c[7:4] == 4'h8})
            `CHK({bw_zero_out, bw_invert_out}, {c[3:0] == 4'h4, c[3:0] == 4'h8})
        end
        i_host.frame(epd_cmd_pkg::CMD_SEQ_OPTION, 1, 16'hC700, rd);
        i_host.frame(epd_cmd_pkg::CMD_SUPPLY_DETECT, 1, 16'h0200, rd);
        `CHK({supply_threshold_out, busy_out}, {3'h4, 1'b0})
        i_host.frame(epd_cmd_pkg::CMD_SUPPLY_DETECT, 1, 16'h0700, rd);
        @(negedge core_clk_in);
        `CHK({supply_threshold_out, busy_out, detect_active_out}, 5'h1F)
        wait_idle();
        i_host.frame(epd_cmd_pkg::CMD_STATUS_READ, 1, 16'h0, rd);
        `CHK(rd[5], 1'b1)
        av(0, epd_cmd_pkg::REG_IRQ_STATUS, 0);
        `CHK(q[2:0], 3'h1)
        i_host.frame(epd_cmd_pkg::CMD_MASTER_ACT, 0, 16'h0, rd);
        @(negedge core_clk_in);
        `CHK({busy_out, update_active_out, update_stages_out}, 10'h3C7)
        wait_idle();
        av(0, epd_cmd_pkg::REG_IRQ_STATUS, 0);
        `CHK(q[2:0], 3'h2)
        av(0, epd_cmd_pkg::REG_TEMP, 0);
        `CHK({q[17:0], update_stages_out}, {18'h20A5C, 8'h00})
        finish_test();
    end
endmodule : tb_epaper_sense_update_commands
